// ==== verilog/mtd_regs.svh ====
// register offsets, field positions and reset values of the magnetic
// threshold event detector; definitions only, included by bare name
`ifndef MTD_REGS_SVH
`define MTD_REGS_SVH

// register offsets on the device register port
`define MTD_ADDR_SRC      8'h53
`define MTD_ADDR_X_UPPER  8'h54
`define MTD_ADDR_X_LOWER  8'h55
`define MTD_ADDR_Y_UPPER  8'h56
`define MTD_ADDR_Y_LOWER  8'h57
`define MTD_ADDR_Z_UPPER  8'h58
`define MTD_ADDR_Z_LOWER  8'h59
`define MTD_ADDR_DB_COUNT 8'h5A

// source and x upper register field positions
`define MTD_SRC_EA_BIT    7
`define MTD_DBCLR_BIT     7

// widths and reset values
`define MTD_THS_W         15
`define MTD_SMP_W         16
`define MTD_RST_BYTE      8'h00
`define MTD_RST_THS       15'h0000

`endif

// ==== verilog/mtd_pkg.sv ====
// shared types of the magnetic threshold event detector
// assumes mtd_regs.svh supplies the widths
`include "mtd_regs.svh"

package mtd_pkg;
   typedef logic [`MTD_THS_W-1:0] mtd_ths_t;   // unsigned magnitude
   typedef logic signed [`MTD_SMP_W-1:0] mtd_smp_t;
   typedef logic [7:0] mtd_byte_t;
endpackage

// ==== verilog/mtd_axis_cmp.sv ====
// one axis: offset correction, magnitude and threshold compare
// assumes samples and offsets come from logic on the same clock
`timescale 1ns/1ps

module mtd_axis_cmp (
   // sample path
   input  wire mtd_pkg::mtd_smp_t sample_in,
   input  wire mtd_pkg::mtd_smp_t offset_in,
   input  wire logic              raw_mode_in,
   // threshold
   input  wire mtd_pkg::mtd_ths_t ths_in,
   // results
   output logic                   above_out,
   output logic                   below_out,
   output logic                   neg_out
);

   logic signed [16:0] corr;
   logic        [16:0] mag;

   // one extra bit keeps sample plus offset from wrapping
   always_comb begin
      if (raw_mode_in) begin
         corr = {sample_in[15], sample_in};
      end else begin
         corr = {sample_in[15], sample_in} + {offset_in[15], offset_in};
      end
      mag       = corr[16] ? 17'(-corr) : 17'(corr);
      above_out = mag >= {2'h0, ths_in};
      below_out = mag <= {2'h0, ths_in};
      neg_out   = corr[16];
   end

endmodule

// ==== verilog/mtd_debounce.sv ====
// debounce counter stepped once per output_sample_rate period, every other one in hybrid mode
// assumes step_in is a one-cycle pulse on the same clock
`timescale 1ns/1ps

module mtd_debounce (
   // clock and reset
   input  wire logic       sys_clk_in,
   input  wire logic       nrst_in,
   input  wire logic       ce_in,
   // control
   input  wire logic       step_in,
   input  wire logic       cond_in,
   input  wire logic       clr_mode_in,
   input  wire logic [7:0] limit_in,
   // status
   output logic [7:0]      cnt_out,
   output logic            reached_out
);

   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic       cond_q;
   logic       cond_d;

   ////////////////////////////////////////////////////////////////////////
   // next count; a lowered limit clamps on the next clock, so the count sits
   // above it for one cycle at most, even between samples
   always_comb begin
      cnt_d  = cnt_q;
      cond_d = cond_q;
      if (step_in) begin
         cond_d = cond_in;
         if (cond_in) begin
            cnt_d = (cnt_q < limit_in) ? 8'(cnt_q + 8'h01) : limit_in;
         end else if (clr_mode_in) begin
            cnt_d = 8'h00;
         end else if (cnt_q != 8'h00) begin
            cnt_d = 8'(cnt_q - 8'h01);
         end
      end
      if (cnt_d > limit_in) begin
         cnt_d = limit_in;
      end
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_q  <= 8'h00;
         cond_q <= 1'b0;
      end else if (ce_in) begin
         cnt_q  <= cnt_d;
         cond_q <= cond_d;
      end
   end

   // event once the count reaches the programmed value on a true sample
   assign cnt_out     = cnt_q;
   assign reached_out = (cnt_q == limit_in) && cond_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_DB_SAT: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && $stable(limit_in) |-> cnt_q <= limit_in)
      else $error("debounce count above limit");

   AST_DB_CLR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && step_in && !cond_in && clr_mode_in |=> cnt_q == 8'h00)
      else $error("debounce count not cleared");

   AST_DB_DEC: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && step_in && !cond_in && !clr_mode_in && cnt_q != 8'h00
      && cnt_q <= limit_in && $stable(limit_in)
      |=> cnt_q == 8'($past(cnt_q) - 8'h01))
      else $error("debounce count not decremented");

   AST_DB_INC: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && step_in && cond_in && cnt_q < limit_in
      |=> cnt_q == 8'($past(cnt_q) + 8'h01))
      else $error("debounce count not incremented");

   AST_DB_FLAG: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && step_in && cond_in && cnt_q == limit_in && $stable(limit_in)
      |=> reached_out)
      else $error("event not raised at debounce count");

endmodule

// ==== verilog/mtd_top.sv ====
// magnetic threshold event detector: register port, per-axis compare,
// debounce, source register and interrupt pin routing
// assumes samples, config bits and register strobes share sys_clk_in;
// sample_tick_in pulses once per output_sample_rate period
//
// Contract
// - source register shows the event driving the flag, or the latched one
// - event-active bit is 1 while the count equals the programmed count and the last sampled enabled-axis combination is true
// - each axis has a high-event bit, 1 when that axis detected an event
// - each axis polarity bit: 0 positive field, 1 negative field; reads 0 while its high-event bit is 0
// - a disabled axis reads its event and polarity bits as zero
// - each threshold is an unsigned 15-bit magnitude, 0.1 uT per step
// - with raw mode off, compare offset-corrected samples
// - upper byte low seven bits hold threshold 14:8, lower byte 7:0
// - debounce-mode bit 1 clears the counter when the condition fails
// - debounce-mode bit 0 decrements the counter when the condition fails
// - an 8-bit debounce count sets the samples needed for an event
// - event flag sets when the counter reaches the programmed count
// - counter saturates at the programmed count
// - counter steps once per sample period, every other one in hybrid mode
// - select 0: all enabled axes at or below; 1: any enabled at or above
// - latched flag holds until source read; unlatched follows detection
// - enabled flag goes to pin two when route is 0, pin one when 1
`timescale 1ns/1ps
`include "mtd_regs.svh"

module mtd_top (
   // clock, reset, enable
   input  wire logic              sys_clk_in,
   input  wire logic              nrst_in,
   input  wire logic              ce_in,
   // register port
   input  wire logic [7:0]        reg_addr_in,
   input  wire logic              reg_wr_in,
   input  wire logic [7:0]        reg_wdata_in,
   input  wire logic              reg_rd_in,
   output logic [7:0]             reg_rdata_out,
   // sample path
   input  wire logic              sample_tick_in,
   input  wire logic              hybrid_mode_in,
   input  wire logic              raw_mode_in,
   input  wire mtd_pkg::mtd_smp_t smp_x_in,
   input  wire mtd_pkg::mtd_smp_t smp_y_in,
   input  wire mtd_pkg::mtd_smp_t smp_z_in,
   input  wire mtd_pkg::mtd_smp_t off_x_in,
   input  wire mtd_pkg::mtd_smp_t off_y_in,
   input  wire mtd_pkg::mtd_smp_t off_z_in,
   // configuration bits
   input  wire logic              cfg_latch_en_in,
   input  wire logic              cfg_or_mode_in,
   input  wire logic [2:0]        cfg_axis_en_in,
   input  wire logic              cfg_int_en_in,
   input  wire logic              cfg_int_route_in,
   // interrupt pins and flag
   input  wire logic              irq_one_other_in,
   input  wire logic              irq_two_other_in,
   output logic                   irq_pin_one_out,
   output logic                   irq_pin_two_out,
   output logic                   event_active_flag_out
);

   mtd_pkg::mtd_smp_t smp [3];
   mtd_pkg::mtd_smp_t off [3];
   mtd_pkg::mtd_ths_t ths_q [3];
   mtd_pkg::mtd_ths_t ths_d [3];
   logic       dbclr_q, dbclr_d;
   logic [7:0] limit_q, limit_d;
   logic [2:0] above, below, neg;
   logic       phase_q, phase_d;
   logic       step;
   logic       cond;
   logic       reached;
   logic [5:0] axis_q, axis_d;
   logic [7:0] lat_q, lat_d;
   logic [7:0] live;
   logic [7:0] src_view;
   logic       src_rd;
   logic [7:0] rdata_q, rdata_d;
   logic       flag_q, irq1_q, irq2_q;

   assign smp = '{smp_x_in, smp_y_in, smp_z_in};
   assign off = '{off_x_in, off_y_in, off_z_in};

   // spread a 3-bit axis vector onto the {he,hp} pairs of the source byte
   function automatic logic [5:0] pair_mask(input logic [2:0] en);
      pair_mask = {en[2], en[2], en[1], en[1], en[0], en[0]};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // per-axis compare
   for (genvar i = 0; i < 3; i++) begin : g_axis
      mtd_axis_cmp u_cmp (
         .sample_in   (smp[i]),
         .offset_in   (off[i]),
         .raw_mode_in (raw_mode_in),
         .ths_in      (ths_q[i]),
         .above_out   (above[i]),
         .below_out   (below[i]),
         .neg_out     (neg[i])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes; threshold and debounce registers
   always_comb begin
      ths_d   = ths_q;
      dbclr_d = dbclr_q;
      limit_d = limit_q;
      if (reg_wr_in) begin
         if (reg_addr_in == `MTD_ADDR_X_UPPER) begin
            dbclr_d         = reg_wdata_in[`MTD_DBCLR_BIT];
            ths_d[0][14:8]  = reg_wdata_in[6:0];
         end else if (reg_addr_in == `MTD_ADDR_X_LOWER) begin
            ths_d[0][7:0]   = reg_wdata_in;
         end else if (reg_addr_in == `MTD_ADDR_Y_UPPER) begin
            ths_d[1][14:8]  = reg_wdata_in[6:0];
         end else if (reg_addr_in == `MTD_ADDR_Y_LOWER) begin
            ths_d[1][7:0]   = reg_wdata_in;
         end else if (reg_addr_in == `MTD_ADDR_Z_UPPER) begin
            ths_d[2][14:8]  = reg_wdata_in[6:0];
         end else if (reg_addr_in == `MTD_ADDR_Z_LOWER) begin
            ths_d[2][7:0]   = reg_wdata_in;
         end else if (reg_addr_in == `MTD_ADDR_DB_COUNT) begin
            limit_d         = reg_wdata_in;
         end
      end
   end

   // thresholds held as 15-bit magnitudes; bit 15 does not exist
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ths_q   <= '{`MTD_RST_THS, `MTD_RST_THS, `MTD_RST_THS};
         dbclr_q <= 1'b0;
         limit_q <= `MTD_RST_BYTE;
      end else if (ce_in) begin
         ths_q   <= ths_d;
         dbclr_q <= dbclr_d;
         limit_q <= limit_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sample step; hybrid mode takes every second tick, doubling the step
   always_comb begin
      phase_d = phase_q;
      if (sample_tick_in) begin
         phase_d = hybrid_mode_in ? !phase_q : 1'b0;
      end
   end

   assign step = sample_tick_in && (!hybrid_mode_in || phase_q);

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         phase_q <= 1'b0;
      end else if (ce_in) begin
         phase_q <= phase_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event condition; with no axis enabled the and-form stays false
   always_comb begin
      if (cfg_or_mode_in) begin
         cond = |(cfg_axis_en_in & above);
      end else begin
         cond = (cfg_axis_en_in != 3'h0)
              && (&(~cfg_axis_en_in | below));
      end
   end

   mtd_debounce u_db (
      .sys_clk_in  (sys_clk_in),
      .nrst_in     (nrst_in),
      .ce_in       (ce_in),
      .step_in     (step),
      .cond_in     (cond),
      .clr_mode_in (dbclr_q),
      .limit_in    (limit_q),
      .cnt_out     (),
      .reached_out (reached)
   );

   ////////////////////////////////////////////////////////////////////////
   // per-axis flags caught at each step, then the source views
   always_comb begin
      axis_d = axis_q;
      if (step) begin
         for (int i = 0; i < 3; i++) begin
            axis_d[2*i+1] = cfg_or_mode_in ? above[i] : below[i];
            axis_d[2*i]   = neg[i] && axis_d[2*i+1];
         end
      end
   end

   assign live   = {reached, 1'b0, axis_q};
   assign src_rd = reg_rd_in && (reg_addr_in == `MTD_ADDR_SRC);

   // latch: a new event in the read cycle wins over the clear
   always_comb begin
      lat_d = lat_q;
      if (src_rd) begin
         lat_d = 8'h00;
      end
      if (reached) begin
         lat_d = lat_q | live;
      end
   end

   always_comb begin
      src_view      = cfg_latch_en_in ? lat_q : live;
      src_view[5:0] = src_view[5:0] & pair_mask(cfg_axis_en_in);
   end

   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         axis_q <= 6'h00;
         lat_q  <= `MTD_RST_BYTE;
      end else if (ce_in) begin
         axis_q <= axis_d;
         lat_q  <= lat_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data; unmapped offsets read zero, reserved bit 7 of y/z reads 0
   always_comb begin
      rdata_d = rdata_q;
      if (reg_rd_in) begin
         if (reg_addr_in == `MTD_ADDR_SRC) begin
            rdata_d = src_view;
         end else if (reg_addr_in == `MTD_ADDR_X_UPPER) begin
            rdata_d = {dbclr_q, ths_q[0][14:8]};
         end else if (reg_addr_in == `MTD_ADDR_X_LOWER) begin
            rdata_d = ths_q[0][7:0];
         end else if (reg_addr_in == `MTD_ADDR_Y_UPPER) begin
            rdata_d = {1'b0, ths_q[1][14:8]};
         end else if (reg_addr_in == `MTD_ADDR_Y_LOWER) begin
            rdata_d = ths_q[1][7:0];
         end else if (reg_addr_in == `MTD_ADDR_Z_UPPER) begin
            rdata_d = {1'b0, ths_q[2][14:8]};
         end else if (reg_addr_in == `MTD_ADDR_Z_LOWER) begin
            rdata_d = ths_q[2][7:0];
         end else if (reg_addr_in == `MTD_ADDR_DB_COUNT) begin
            rdata_d = limit_q;
         end else begin
            rdata_d = 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flag and interrupt pins, registered so the pins never glitch
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_q <= `MTD_RST_BYTE;
         flag_q  <= 1'b0;
         irq1_q  <= 1'b0;
         irq2_q  <= 1'b0;
      end else if (ce_in) begin
         rdata_q <= rdata_d;
         flag_q  <= src_view[`MTD_SRC_EA_BIT];
         irq1_q  <= irq_one_other_in || (cfg_int_en_in && cfg_int_route_in
                    && src_view[`MTD_SRC_EA_BIT]);
         irq2_q  <= irq_two_other_in || (cfg_int_en_in && !cfg_int_route_in
                    && src_view[`MTD_SRC_EA_BIT]);
      end
   end

   assign reg_rdata_out         = rdata_q;
   assign event_active_flag_out = flag_q;
   assign irq_pin_one_out       = irq1_q;
   assign irq_pin_two_out       = irq2_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   AST_MASK_ZERO: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && reg_rd_in && reg_addr_in == `MTD_ADDR_SRC && !cfg_axis_en_in[0]
      |=> reg_rdata_out[1:0] == 2'h0)
      else $error("disabled x axis bits not zero");

   AST_SRC_READ: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && src_rd |=> reg_rdata_out == $past(src_view))
      else $error("source read data wrong");

   AST_LATCH_HOLD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && lat_q[7] && !src_rd |=> lat_q[7])
      else $error("latched event dropped without read");

   AST_LATCH_CLR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && src_rd && !reached |=> lat_q == 8'h00)
      else $error("latched source not cleared by read");

   AST_LIVE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && !cfg_latch_en_in ##1 ce_in && !cfg_latch_en_in
      |-> event_active_flag_out == $past(reached))
      else $error("unlatched flag does not follow detection");

   AST_ROUTE_ONE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && cfg_int_en_in && cfg_int_route_in && src_view[7]
      |=> irq_pin_one_out)
      else $error("flag missing on pin one");

   AST_ROUTE_TWO: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && cfg_int_en_in && !cfg_int_route_in && src_view[7]
      && !irq_one_other_in |=> irq_pin_two_out && !irq_pin_one_out)
      else $error("flag on wrong interrupt pin");

   AST_THS_WR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && reg_wr_in && reg_addr_in == `MTD_ADDR_X_UPPER
      |=> ths_q[0][14:8] == $past(reg_wdata_in[6:0])
      && dbclr_q == $past(reg_wdata_in[7]))
      else $error("x upper threshold write lost");

   AST_HYB_STEP: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
      ce_in && hybrid_mode_in && step |=> !phase_q)
      else $error("hybrid mode stepped on consecutive ticks");

endmodule

// ==== verification/mtd_host_model.sv ====
// host side of the register port: one-cycle read and write strobes
// assumes the bench calls the tasks; signals move on falling edges
`timescale 1ns/1ps

module mtd_host_model (
   // clock
   input  wire logic       sys_clk_in,
   // register port
   output logic [7:0]      reg_addr_out,
   output logic            reg_wr_out,
   output logic [7:0]      reg_wdata_out,
   output logic            reg_rd_out,
   input  wire logic [7:0] reg_rdata_in
);
   ////////////////////////////////////////////////////////////////////////
   // idle bus at time zero
   initial begin
      reg_addr_out  = 8'h00;
      reg_wr_out    = 1'b0;
      reg_wdata_out = 8'h00;
      reg_rd_out    = 1'b0;
   end

   // idle address and data are inverted so a stale value never looks valid
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge sys_clk_in);
      reg_addr_out  = addr;
      reg_wdata_out = data;
      reg_wr_out    = 1'b1;
      @(negedge sys_clk_in);
      reg_wr_out    = 1'b0;
      reg_addr_out  = ~addr;
      reg_wdata_out = ~data;
   endtask

   // read data is registered, so it is taken one edge after the strobe
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(negedge sys_clk_in);
      reg_addr_out = addr;
      reg_rd_out   = 1'b1;
      @(negedge sys_clk_in);
      reg_rd_out   = 1'b0;
      reg_addr_out = ~addr;
      data         = reg_rdata_in;
   endtask
endmodule

// ==== verification/mtd_top_tb.sv ====
// self-checking bench of the threshold event detector
// assumes the host model drives the register port on falling edges
`timescale 1ns/1ps
`include "mtd_regs.svh"

module mtd_top_tb;
   logic              clk, nrst, tick_p, hyb, raw, latch, orm, ien, route;
   logic [2:0]        en;
   logic [7:0]        addr, wdata, rdata, rd_val;
   logic              wr, rd, pin1, pin2, flag, oth1;
   mtd_pkg::mtd_smp_t sx, sy, sz, ox;
   integer            num_errors, n_compared;

   mtd_host_model host (.sys_clk_in(clk), .reg_addr_out(addr),
      .reg_wr_out(wr), .reg_wdata_out(wdata), .reg_rd_out(rd),
      .reg_rdata_in(rdata));

   mtd_top uut (.sys_clk_in(clk), .nrst_in(nrst), .ce_in(1'b1),
      .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .sample_tick_in(tick_p),
      .hybrid_mode_in(hyb), .raw_mode_in(raw), .smp_x_in(sx),
      .smp_y_in(sy), .smp_z_in(sz), .off_x_in(ox), .off_y_in(16'h0000),
      .off_z_in(16'h0000), .cfg_latch_en_in(latch), .cfg_or_mode_in(orm),
      .cfg_axis_en_in(en), .cfg_int_en_in(ien), .cfg_int_route_in(route),
      .irq_one_other_in(oth1), .irq_two_other_in(1'b0),
      .irq_pin_one_out(pin1), .irq_pin_two_out(pin2),
      .event_active_flag_out(flag));

   ////////////////////////////////////////////////////////////////////////
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // verdict and end of run, shared by the main flow and the watchdog
   task automatic results;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a, rd_val);
      chk($sformatf("register %h", a), e, rd_val);
   endtask

   // one sample period; the pause lets counter and pins settle
   task automatic tick(input mtd_pkg::mtd_smp_t x, y, z);
      @(negedge clk);
      sx     = x;
      sy     = y;
      sz     = z;
      tick_p = 1'b1;
      @(negedge clk);
      tick_p = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   // fresh reset, thresholds of 100 on every axis, given debounce setup
   task automatic setup(input logic o, input logic [2:0] e, input logic c,
                        input logic [7:0] cnt);
      @(negedge clk);
      nrst  = 1'b0;
      orm   = o;
      en    = e;
      latch = 1'b0;
      hyb   = 1'b0;
      raw   = 1'b0;
      route = 1'b0;
      ox    = 16'h0000;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      host.wr(`MTD_ADDR_X_UPPER, {c, 7'h00});
      host.wr(`MTD_ADDR_X_LOWER, 8'h64);
      host.wr(`MTD_ADDR_Y_LOWER, 8'h64);
      host.wr(`MTD_ADDR_Z_LOWER, 8'h64);
      host.wr(`MTD_ADDR_DB_COUNT, cnt);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // watchdog: a hang counts as a mismatch
   initial begin
      #(40 * 30000);
      num_errors++;
      $display("run timed out");
      results();
   end

   // main sequence
   initial begin
      {oth1, tick_p, hyb, raw, latch, orm, ien, route} = 8'h00;
      {sx, sy, sz, ox} = 64'h0;
      en = 3'h0;
      nrst = 1'b0;
      num_errors = 0;
      n_compared = 0;
      repeat (6) @(negedge clk);
      nrst = 1'b1;
      for (int a = 8'h53; a <= 8'h5A; a++) rd_chk(8'(a), 8'h00);
      rd_chk(8'h60, 8'h00);
      host.wr(`MTD_ADDR_X_UPPER, 8'hFF);
      host.wr(`MTD_ADDR_Y_UPPER, 8'hFF);
      host.wr(`MTD_ADDR_Z_UPPER, 8'hFF);
      host.wr(`MTD_ADDR_Z_LOWER, 8'hA5);
      host.wr(`MTD_ADDR_DB_COUNT, 8'hC3);
      host.wr(8'h60, 8'hFF);
      rd_chk(`MTD_ADDR_X_UPPER, 8'hFF);
      rd_chk(`MTD_ADDR_Y_UPPER, 8'h7F);
      rd_chk(`MTD_ADDR_Z_UPPER, 8'h7F);
      rd_chk(`MTD_ADDR_Z_LOWER, 8'hA5);
      rd_chk(`MTD_ADDR_DB_COUNT, 8'hC3);
      rd_chk(8'h60, 8'h00);
      $display("test registers done");
      // any-above at the exact threshold, routed to pin two
      ien = 1'b1;
      setup(1'b1, 3'b001, 1'b1, 8'h02);
      tick(16'sd99, 0, 0);
      tick(16'sd100, 0, 0);
      chk("flag one of two", 8'h00, {7'h00, flag});
      tick(16'sd100, 0, 0);
      rd_chk(`MTD_ADDR_SRC, 8'h82);
      chk("pin two", 8'h01, {7'h00, pin2});
      chk("pin one", 8'h00, {7'h00, pin1});
      $display("test or mode done");
      // all-below at the exact threshold
      setup(1'b0, 3'b001, 1'b1, 8'h01);
      tick(16'sd100, 0, 0);
      rd_chk(`MTD_ADDR_SRC, 8'h82);
      tick(16'sd101, 0, 0);
      chk("flag and mode", 8'h00, {7'h00, flag});
      $display("test and mode done");
      // negative field with offset, then raw mode drops the offset
      setup(1'b1, 3'b001, 1'b1, 8'h01);
      ox = -16'sd60;
      tick(-16'sd50, 0, 0);
      rd_chk(`MTD_ADDR_SRC, 8'h83);
      raw = 1'b1;
      tick(-16'sd50, 0, 0);
      chk("flag raw", 8'h00, {7'h00, flag});
      $display("test offset done");
      // each axis alone; disabled axes read zero
      for (int i = 0; i < 3; i++) begin
         setup(1'b1, 3'(3'b001 << i), 1'b1, 8'h01);
         tick(-16'sd150, -16'sd150, -16'sd150);
         rd_chk(`MTD_ADDR_SRC, 8'(8'h80 | (8'h03 << (2 * i))));
      end
      $display("test axes done");
      // decrement mode with saturation
      setup(1'b1, 3'b001, 1'b0, 8'h02);
      repeat (5) tick(16'sd200, 0, 0);
      tick(0, 0, 0);
      chk("flag after dip", 8'h00, {7'h00, flag});
      tick(16'sd200, 0, 0);
      chk("flag recovered", 8'h01, {7'h00, flag});
      // clear mode restarts the count; decrement would keep one step
      setup(1'b1, 3'b001, 1'b1, 8'h03);
      repeat (2) tick(16'sd200, 0, 0);
      tick(0, 0, 0);
      repeat (2) tick(16'sd200, 0, 0);
      chk("flag cleared count", 8'h00, {7'h00, flag});
      tick(16'sd200, 0, 0);
      chk("flag after clear", 8'h01, {7'h00, flag});
      $display("test debounce done");
      // latched event to pin one, cleared by a source read
      setup(1'b1, 3'b001, 1'b1, 8'h01);
      latch = 1'b1;
      route = 1'b1;
      tick(16'sd200, 0, 0);
      chk("pin one", 8'h01, {7'h00, pin1});
      tick(0, 0, 0);
      chk("flag held", 8'h01, {7'h00, flag});
      rd_chk(`MTD_ADDR_SRC, 8'h82);
      rd_chk(`MTD_ADDR_SRC, 8'h00);
      $display("test latch done");
      // hybrid mode steps on every second tick only
      setup(1'b1, 3'b001, 1'b1, 8'h02);
      hyb = 1'b1;
      ien = 1'b0;
      repeat (3) tick(16'sd200, 0, 0);
      chk("flag hybrid three", 8'h00, {7'h00, flag});
      tick(16'sd200, 0, 0);
      chk("flag hybrid four", 8'h01, {7'h00, flag});
      chk("pin two disabled", 8'h00, {7'h00, pin2});
      oth1 = 1'b1;
      repeat (2) @(negedge clk);
      chk("pin one other", 8'h01, {7'h00, pin1});
      oth1 = 1'b0;
      $display("test hybrid done");
      results();
   end
endmodule
